// file: common/csc_params.svh
// Purpose: Offsets, field positions, reset values and timing constants
//          for the clock synthesizer configuration register bank.
// Assumes: Byte address is four times the register index.
// Notes:   Times are in microseconds; cycle counts derive from CSC_CLK_MHZ.
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// ==========================================================
// Register indices
`define CSC_IDX_BCNT 6'h0C
`define CSC_IDX_SPRD 6'h0D
`define CSC_IDX_FTAB 6'h0E
`define CSC_IDX_DIVL 6'h0F
`define CSC_IDX_DIVH 6'h10
`define CSC_IDX_OVR 6'h11
`define CSC_IDX_WDV 6'h12
`define CSC_IDX_WDC 6'h13
`define CSC_IDX_ISTAT 6'h14
`define CSC_IDX_IMASK 6'h15

// ==========================================================
// Reset values
`define CSC_RST_BCNT 8'h0D
`define CSC_RST_SPRD 8'h00
`define CSC_RST_FTAB 8'h01
`define CSC_RST_DIVL 8'h00
`define CSC_RST_DIVH 8'h00
`define CSC_RST_OVR 8'h00
`define CSC_RST_WDV 8'h06
`define CSC_RST_WDC 8'h00

// ==========================================================
// Field positions
`define CSC_FTAB_SRC 7
`define CSC_OVR_CPU 7
`define CSC_OVR_REF 6
`define CSC_WDV_BASE 7
`define CSC_WDC_EN 7
`define CSC_WDC_ALARM 6
`define CSC_INT_WDT 0
`define CSC_INT_FCHG 1

// ==========================================================
// Timing
`define CSC_CLK_MHZ 40
`define CSC_WDT_BASE0_US 293600
`define CSC_WDT_BASE1_US 1174000
`define CSC_STRAP_SETTLE 2'h2

`endif

// file: common/csc_pkg.sv
// Purpose: Types shared by the clock synthesizer configuration bank.
// Assumes: Constants come from csc_params.svh.
// Notes:   The whole module state is one packed struct.
package csc_pkg;

    // ==========================================================
    // Watchdog states, Gray along idle-run-fired
    typedef enum logic [1:0] {
        WD_IDLE = 2'h0,
        WD_RUN = 2'h1,
        WD_FIRED = 2'h3
    } csc_wd_e;

    // ==========================================================
    // Module state
    typedef struct packed {
        logic tme_s1;
        logic tme_s2;
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        logic [1:0] settle;
        logic strap_done;
        logic [2:0] strap_lat;
        logic [7:0] r_bcnt;
        logic [7:0] r_sprd;
        logic [7:0] r_ftab;
        logic [7:0] r_divl;
        logic [7:0] r_divh;
        logic [7:0] r_ovr;
        logic [7:0] r_wdv;
        logic [7:0] r_wdc;
        logic [1:0] istat;
        logic [1:0] imask;
        logic [4:0] freq_sel;
        csc_wd_e wd;
        logic [25:0] base_cnt;
        logic [4:0] tick_cnt;
        logic [7:0] rdata;
        logic irq;
    } csc_state_s;

endpackage

// file: hw/csc_regs.sv
// Purpose: Configuration register bank of a system clock synthesizer.
// Assumes: One 40 MHz clock; straps and trusted-mode input are async pins.
// Notes:   Registers sit at byte address four times their index.
// Contract
// RULE1 - A six-bit block-read byte count sits in bits 5:0 and resets to thirteen.
// RULE2 - Firmware writes the byte count first when it wants more than thirteen bytes.
// RULE3 - The two-bit spread field picks 0.5, 0.4, 0.3 or 0.6 percent and resets to 00.
// RULE4 - Bit 7 of frequency control picks straps (0) or software select bits 6:2 (1).
// RULE5 - Trusted mode forces the source bit and both divider override enables to 0.
// RULE6 - Select bits 2:0 load from the latched straps at power up, bits 4:3 reset to 0.
// RULE7 - Reference divider is bits 5:0, feedback divider is bits 7:6 plus next register.
// RULE8 - Override bit 7 enables processor loop dividers, bit 6 the reference loop.
// RULE9 - Watchdog bit 7 selects a 293.6 ms or 1.174 s time base, resetting to 0.
// RULE10 - Alarm field 4:2 sets timeout to four times its value in time bases, 000 is zero.
// RULE11 - Firmware always writes zero to watchdog value bit 0.
// RULE12 - With enable set the watchdog starts on a frequency change; clearing stops it.
// RULE13 - Timeout sets a hard-alarm bit cleared by writing one; writing zero does nothing.
// RULE14 - Reserved bits store and read back what is written, from their power-up value; status and mask bits 7:2 keep no write and read zero.
`timescale 1ns/10ps
`include "csc_params.svh"
`default_nettype none

module csc_regs
    import csc_pkg::*;
#(
    parameter int BASE0_CYC = `CSC_WDT_BASE0_US * `CSC_CLK_MHZ,
    parameter int BASE1_CYC = `CSC_WDT_BASE1_US * `CSC_CLK_MHZ
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TRUSTED_MODE_INPUT_I,
    input wire logic FREQ_STRAP_HIGH_I,
    input wire logic FREQ_STRAP_MID_I,
    input wire logic FREQ_STRAP_LOW_I,
    output logic [5:0] BLOCK_COUNT_O,
    output logic [1:0] SPREAD_DEPTH_O,
    output logic [4:0] FREQ_SEL_O,
    output logic [5:0] CPU_REF_DIV_O,
    output logic [9:0] CPU_FB_DIV_O,
    output logic CPU_DIV_OVR_EN_O,
    output logic REF_DIV_OVR_EN_O,
    output logic WDT_ALARM_O,
    output logic IRQ_O
);

    // ==========================================================
    // Decode and derived terms
    csc_state_s s_reg;
    csc_state_s s_next;
    logic [5:0] idx;
    logic hit;
    logic wr_bcnt, wr_sprd, wr_ftab, wr_divl, wr_divh, wr_ovr, wr_wdv, wr_wdc;
    logic wr_istat, wr_imask;
    logic [4:0] freq_new;
    logic freq_chg;
    logic [4:0] limit;
    logic [25:0] base_lim;
    logic [1:0] ev;

    assign idx = ADDR_I[7:2];
    assign hit = (ADDR_I[1:0] == 2'h0);
    assign wr_bcnt = WR_I && hit && (idx == `CSC_IDX_BCNT);
    assign wr_sprd = WR_I && hit && (idx == `CSC_IDX_SPRD);
    assign wr_ftab = WR_I && hit && (idx == `CSC_IDX_FTAB);
    assign wr_divl = WR_I && hit && (idx == `CSC_IDX_DIVL);
    assign wr_divh = WR_I && hit && (idx == `CSC_IDX_DIVH);
    assign wr_ovr = WR_I && hit && (idx == `CSC_IDX_OVR);
    assign wr_wdv = WR_I && hit && (idx == `CSC_IDX_WDV);
    assign wr_wdc = WR_I && hit && (idx == `CSC_IDX_WDC);
    assign wr_istat = WR_I && hit && (idx == `CSC_IDX_ISTAT);
    assign wr_imask = WR_I && hit && (idx == `CSC_IDX_IMASK);

    // Source bit is already forced low in trusted mode
    assign freq_new = s_reg.r_ftab[`CSC_FTAB_SRC] ? s_reg.r_ftab[6:2] // see RULE4
                                                 : {2'h0, s_reg.strap_lat};
    assign freq_chg = s_reg.strap_done && (freq_new != s_reg.freq_sel);
    assign limit = {s_reg.r_wdv[4:2], 2'h0}; // see RULE10
    assign base_lim = s_reg.r_wdv[`CSC_WDV_BASE] ? BASE1_CYC[25:0] - 26'h1 // see RULE9
                                                : BASE0_CYC[25:0] - 26'h1;

    // ==========================================================
    // Next state
    always_comb begin
        s_next = s_reg;
        ev = 2'h0;
        s_next.tme_s1 = TRUSTED_MODE_INPUT_I;
        s_next.tme_s2 = s_reg.tme_s1;
        s_next.strap_s1 = {FREQ_STRAP_HIGH_I, FREQ_STRAP_MID_I, FREQ_STRAP_LOW_I};
        s_next.strap_s2 = s_reg.strap_s1;

        // Plain byte stores keep reserved bits as written
        if (wr_bcnt) begin
            s_next.r_bcnt = WDATA_I; // see RULE1 see RULE14
        end
        if (wr_sprd) begin
            s_next.r_sprd = WDATA_I; // see RULE3
        end
        if (wr_ftab) begin
            s_next.r_ftab = WDATA_I; // see RULE4
        end
        if (wr_divl) begin
            s_next.r_divl = WDATA_I; // see RULE7
        end
        if (wr_divh) begin
            s_next.r_divh = WDATA_I; // see RULE7
        end
        if (wr_ovr) begin
            s_next.r_ovr = WDATA_I; // see RULE8
        end
        if (wr_wdv) begin
            s_next.r_wdv = WDATA_I; // see RULE9
        end
        if (wr_wdc) begin
            s_next.r_wdc = WDATA_I;
            s_next.r_wdc[`CSC_WDC_ALARM] = s_reg.r_wdc[`CSC_WDC_ALARM]
                                           && !WDATA_I[`CSC_WDC_ALARM]; // see RULE13
        end
        if (wr_imask) begin
            s_next.imask = WDATA_I[1:0];
        end
        if (wr_istat) begin
            s_next.istat = s_reg.istat & ~WDATA_I[1:0];
        end

        if (s_reg.tme_s2) begin
            s_next.r_ftab[`CSC_FTAB_SRC] = 1'b0; // see RULE5
            s_next.r_ovr[`CSC_OVR_CPU] = 1'b0; // see RULE5
            s_next.r_ovr[`CSC_OVR_REF] = 1'b0; // see RULE5
        end

        // Wait for the synchroniser to fill before latching straps
        if (!s_reg.strap_done) begin
            if (s_reg.settle == `CSC_STRAP_SETTLE) begin
                s_next.strap_done = 1'b1;
                s_next.strap_lat = s_reg.strap_s2;
                s_next.r_ftab[4:2] = s_reg.strap_s2; // see RULE6
            end else begin
                s_next.settle = s_reg.settle + 2'h1;
            end
        end

        s_next.freq_sel = s_reg.strap_done ? freq_new : s_reg.freq_sel;
        if (freq_chg) begin
            ev[`CSC_INT_FCHG] = 1'b1;
        end

        unique case (s_reg.wd)
            WD_IDLE: begin
                s_next.base_cnt = 26'h0;
                s_next.tick_cnt = 5'h0;
                if (s_reg.r_wdc[`CSC_WDC_EN] && freq_chg) begin // see RULE12
                    s_next.wd = (limit == 5'h0) ? WD_FIRED : WD_RUN; // see RULE10
                end
            end
            WD_RUN: begin
                if (!s_reg.r_wdc[`CSC_WDC_EN]) begin
                    s_next.wd = WD_IDLE; // see RULE12
                end else if (s_reg.base_cnt >= base_lim) begin
                    s_next.base_cnt = 26'h0;
                    s_next.tick_cnt = s_reg.tick_cnt + 5'h1;
                    if (s_reg.tick_cnt + 5'h1 >= limit) begin
                        s_next.wd = WD_FIRED; // see RULE10
                    end
                end else begin
                    s_next.base_cnt = s_reg.base_cnt + 26'h1;
                end
            end
            WD_FIRED: begin
                s_next.wd = WD_IDLE;
                ev[`CSC_INT_WDT] = 1'b1;
                s_next.r_wdc[`CSC_WDC_ALARM] = 1'b1; // see RULE13
            end
            default: begin
                s_next.wd = WD_IDLE;
            end
        endcase

        // Set after clear so a same-cycle event survives
        s_next.istat = s_next.istat | ev;
        s_next.irq = |(s_next.istat & s_next.imask);

        s_next.rdata = 8'h00;
        if (RD_I && hit) begin
            unique case (idx)
                `CSC_IDX_BCNT: s_next.rdata = s_reg.r_bcnt;
                `CSC_IDX_SPRD: s_next.rdata = s_reg.r_sprd;
                `CSC_IDX_FTAB: s_next.rdata = s_reg.r_ftab;
                `CSC_IDX_DIVL: s_next.rdata = s_reg.r_divl;
                `CSC_IDX_DIVH: s_next.rdata = s_reg.r_divh;
                `CSC_IDX_OVR: s_next.rdata = s_reg.r_ovr;
                `CSC_IDX_WDV: s_next.rdata = s_reg.r_wdv;
                `CSC_IDX_WDC: s_next.rdata = s_reg.r_wdc;
                `CSC_IDX_ISTAT: s_next.rdata = {6'h00, s_reg.istat};
                `CSC_IDX_IMASK: s_next.rdata = {6'h00, s_reg.imask};
                default: s_next.rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_reg <= '0;
            s_reg.r_bcnt <= `CSC_RST_BCNT; // see RULE1
            s_reg.r_sprd <= `CSC_RST_SPRD; // see RULE3
            s_reg.r_ftab <= `CSC_RST_FTAB; // see RULE14
            s_reg.r_divl <= `CSC_RST_DIVL;
            s_reg.r_divh <= `CSC_RST_DIVH;
            s_reg.r_ovr <= `CSC_RST_OVR;
            s_reg.r_wdv <= `CSC_RST_WDV; // see RULE10
            s_reg.r_wdc <= `CSC_RST_WDC;
            s_reg.wd <= WD_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA_O = s_reg.rdata;
    assign BLOCK_COUNT_O = s_reg.r_bcnt[5:0];
    assign SPREAD_DEPTH_O = s_reg.r_sprd[1:0];
    assign FREQ_SEL_O = s_reg.freq_sel;
    assign CPU_REF_DIV_O = s_reg.r_divl[5:0];
    assign CPU_FB_DIV_O = {s_reg.r_divh, s_reg.r_divl[7:6]};
    assign CPU_DIV_OVR_EN_O = s_reg.r_ovr[`CSC_OVR_CPU];
    assign REF_DIV_OVR_EN_O = s_reg.r_ovr[`CSC_OVR_REF];
    assign WDT_ALARM_O = s_reg.r_wdc[`CSC_WDC_ALARM];
    assign IRQ_O = s_reg.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    AST_BCNT_WR: assert property (wr_bcnt |=> BLOCK_COUNT_O == $past(WDATA_I[5:0])) // see RULE1
        else $error("Block count not stored");
    AST_SPRD_WR: assert property (wr_sprd |=> SPREAD_DEPTH_O == $past(WDATA_I[1:0])) // see RULE3
        else $error("Spread depth not stored");
    AST_SRC_SW: assert property (s_reg.strap_done && s_reg.r_ftab[7] // see RULE4
                                 |=> FREQ_SEL_O == $past(s_reg.r_ftab[6:2]))
        else $error("Software select not followed");
    AST_SRC_HW: assert property (s_reg.strap_done && !s_reg.r_ftab[7] // see RULE4
                                 |=> FREQ_SEL_O == {2'h0, $past(s_reg.strap_lat)})
        else $error("Strap select not followed");
    AST_TRUST: assert property (s_reg.tme_s2 // see RULE5
                                |=> !s_reg.r_ftab[7] && !CPU_DIV_OVR_EN_O && !REF_DIV_OVR_EN_O)
        else $error("Trusted mode did not force bits low");
    AST_STRAP: assert property ($rose(s_reg.strap_done) // see RULE6
                                |-> s_reg.r_ftab[4:2] == s_reg.strap_lat)
        else $error("Strap not loaded into select");
    AST_FB_DIV: assert property (wr_divh |=> CPU_FB_DIV_O[9:2] == $past(WDATA_I)) // see RULE7
        else $error("Feedback divider high bits wrong");
    AST_OVR: assert property (wr_ovr && !s_reg.tme_s2 // see RULE8
                              |=> CPU_DIV_OVR_EN_O == $past(WDATA_I[7]))
        else $error("Override enable not stored");
    AST_BASE: assert property (s_reg.wd == WD_RUN && s_reg.r_wdc[7] // see RULE9
                               && s_reg.base_cnt == base_lim |=> s_reg.base_cnt == 26'h0)
        else $error("Time base did not wrap");
    AST_ZERO: assert property (s_reg.wd == WD_IDLE && s_reg.r_wdc[7] && freq_chg // see RULE10
                               && limit == 5'h0 |=> s_reg.wd == WD_FIRED ##1 WDT_ALARM_O)
        else $error("Zero alarm value did not fire at once");
    AST_STOP: assert property (s_reg.wd == WD_RUN && !s_reg.r_wdc[7] // see RULE12
                               |=> s_reg.wd == WD_IDLE)
        else $error("Watchdog did not stop");
    AST_ALARM: assert property (s_reg.wd == WD_FIRED |=> WDT_ALARM_O && s_reg.istat[0]) // see RULE13
        else $error("Timeout did not set alarm");
    AST_READ: assert property (RD_I && hit && idx == `CSC_IDX_WDV // see RULE14
                               |=> RDATA_O == $past(s_reg.r_wdv) ##1 ($past(RD_I) || RDATA_O == 8'h00))
        else $error("Read data wrong or held");
    AST_DIVL_WR: assert property (wr_divl // see RULE7
                                  |=> CPU_REF_DIV_O == $past(WDATA_I[5:0])
                                  && CPU_FB_DIV_O[1:0] == $past(WDATA_I[7:6]))
        else $error("Divider low register not stored");
    AST_REF_OVR: assert property (wr_ovr && !s_reg.tme_s2 // see RULE8
                                  |=> REF_DIV_OVR_EN_O == $past(WDATA_I[6]))
        else $error("Reference override enable not stored");
    AST_FTAB_WR: assert property (wr_ftab && !s_reg.tme_s2 && s_reg.strap_done // see RULE4
                                  |=> s_reg.r_ftab == $past(WDATA_I))
        else $error("Frequency control not stored");
    AST_WDV_WR: assert property (wr_wdv |=> s_reg.r_wdv == $past(WDATA_I)) // see RULE14
        else $error("Watchdog value not stored as written");
    AST_RUN_HOLD: assert property (s_reg.wd == WD_RUN && s_reg.r_wdc[7] // see RULE10
                                   && s_reg.base_cnt < base_lim |=> s_reg.wd == WD_RUN)
        else $error("Watchdog left run before a tick");
    AST_ALARM_KEEP: assert property (WDT_ALARM_O && !(wr_wdc && WDATA_I[6]) // see RULE13
                                     |=> WDT_ALARM_O)
        else $error("Hard alarm lost without a clear");
    AST_ALARM_CLR: assert property (wr_wdc && WDATA_I[6] && s_reg.wd != WD_FIRED // see RULE13
                                    |=> !WDT_ALARM_O)
        else $error("Hard alarm not cleared");
    AST_IRQ: assert property (IRQ_O == |(s_reg.istat & s_reg.imask)) // see RULE13
        else $error("Interrupt does not follow status and mask");

endmodule // csc_regs

`default_nettype wire

// file: dv/csc_host.sv
// Purpose: Firmware-side bus master for the configuration bank.
// Assumes: One-cycle strobes, read data the cycle after the read strobe.
// Notes:   Idle bus lines show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none

module csc_host (
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // ==========================================================
    // Bus cycles; callers set the byte count first for long reads
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h48) begin
            v[0] = 1'b0;
        end
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~v;
    endtask

    // Alarm clear is a one written to bit 6
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    endtask
endmodule // csc_host

`default_nettype wire

// file: dv/csc_regs_tb.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Short watchdog ticks via parameters.
// Notes:   Read results are checked from a queue by a monitor.
`timescale 1ns/10ps
`default_nettype none

module csc_regs_tb;
    localparam int B0 = 4;
    localparam int B1 = 8;
    logic clk, rst_n, trusted_mode_input, wr, rd, rd_q, covr, rovr, alarm, irq;
    logic [2:0] strap;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] bcnt, rdiv;
    logic [1:0] sprd;
    logic [4:0] fsel;
    logic [9:0] fbdiv;
    logic [31:0] seed, d;
    logic [7:0] m [0:6];
    logic [7:0] exp_q [$];
    logic [7:0] adr_q [$];
    int error_cnt, cmp_count, idx;

    csc_host csc_host_inst (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    csc_regs #(.BASE0_CYC(B0), .BASE1_CYC(B1)) csc_regs_inst (
        .CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .TRUSTED_MODE_INPUT_I(trusted_mode_input), .FREQ_STRAP_HIGH_I(strap[2]),
        .FREQ_STRAP_MID_I(strap[1]), .FREQ_STRAP_LOW_I(strap[0]), .BLOCK_COUNT_O(bcnt),
        .SPREAD_DEPTH_O(sprd), .FREQ_SEL_O(fsel), .CPU_REF_DIV_O(rdiv), .CPU_FB_DIV_O(fbdiv),
        .CPU_DIV_OVR_EN_O(covr), .REF_DIV_OVR_EN_O(rovr), .WDT_ALARM_O(alarm), .IRQ_O(irq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        adr_q.push_back(a);
        csc_host_inst.rd(a);
    endtask

    // Mirror applies the forced bits, so the bank must too
    task automatic wrm(input int i, input logic [7:0] dv);
        logic [7:0] v;
        v = dv;
        if (i == 6) v[0] = 1'b0;
        if (trusted_mode_input && i == 2) v[7] = 1'b0;
        if (trusted_mode_input && i == 5) v[7:6] = 2'b00;
        m[i] = v;
        csc_host_inst.wr(8'h30 + 8'(i * 4), dv);
    endtask

    // Two edges: outputs may sit one flop behind the register
    task automatic chk_out();
        repeat (2) @(negedge clk);
        chk("block_count", 16'(m[0][5:0]), 16'(bcnt));
        chk("spread", 16'(m[1][1:0]), 16'(sprd));
        chk("freq_sel", 16'(m[2][7] ? m[2][6:2] : {2'b00, strap}), 16'(fsel));
        chk("ref_div", 16'(m[3][5:0]), 16'(rdiv));
        chk("fb_div", 16'({m[4], m[3][7:6]}), 16'(fbdiv));
        chk("overrides", 16'(m[5][7:6]), 16'({covr, rovr}));
    endtask

    task automatic wd_start(input logic [7:0] cfg);
        logic [4:0] s;
        csc_host_inst.wr(8'h4C, 8'h40);
        csc_host_inst.wr(8'h50, 8'h03);
        wrm(6, cfg);
        csc_host_inst.wr(8'h4C, 8'h80);
        s = (m[2][7] ? m[2][6:2] : {2'b00, strap}) + 5'h01;
        wrm(2, {1'b1, s, m[2][1:0]});
    endtask

    task automatic wd_case(input logic [7:0] cfg, input int lo);
        int n;
        n = 0;
        wd_start(cfg);
        while (alarm !== 1'b1 && n < lo + 10) begin
            @(negedge clk);
            n++;
        end
        chk("wdt_delay", 16'h1, 16'(n >= lo && n <= lo + 6));
        rd_chk(8'h50, 8'h03);
        repeat (2) @(negedge clk);
        chk("irq", 16'h1, 16'(irq));
        csc_host_inst.wr(8'h54, 8'h00);
        repeat (2) @(negedge clk);
        chk("irq_masked", 16'h0, 16'(irq));
        csc_host_inst.wr(8'h54, 8'h01);
        csc_host_inst.wr(8'h4C, 8'h80);
        rd_chk(8'h4C, 8'hC0);
        csc_host_inst.wr(8'h4C, 8'hC0);
        rd_chk(8'h4C, 8'h80);
        csc_host_inst.wr(8'h50, 8'h01);
        repeat (2) @(negedge clk);
        chk("irq_clear", 16'h0, 16'({alarm, irq}));
    endtask

    // ==========================================================
    // Read monitor
    // Falling edge, so read data has settled and never races its launch
    always @(negedge clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                chk("rdata_queue", 16'h1, 16'h0);
            end else begin
                chk($sformatf("rdata_%h", adr_q.pop_front()), 16'(exp_q.pop_front()), 16'(rdata));
            end
        end
        rd_q <= rd;
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // ==========================================================
    // Scenarios
    initial begin
        rst_n = 1'b0;
        trusted_mode_input = 1'b0;
        strap = 3'b101;
        seed = 32'd76;
        error_cnt = 0;
        cmp_count = 0;
        m = '{8'h0D, 8'h00, {3'b000, 3'b101, 2'b01}, 8'h00, 8'h00, 8'h00, 8'h06};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 7; i++) rd_chk(8'h30 + 8'(i * 4), m[i]);
        chk_out();
        rd_chk(8'h4C, 8'h00);
        rd_chk(8'h54, 8'h00);
        csc_host_inst.wr(8'h58, 8'hFF);
        rd_chk(8'h58, 8'h00);
        rd_chk(8'h31, 8'h00);
        wrm(0, 8'h28);
        chk_out();
        for (int c = 0; c < 4; c++) begin
            wrm(1, 8'(c));
            chk_out();
        end
        for (int i = 0; i < 24; i++) begin
            d = xs();
            idx = int'(d % 7);
            d = xs();
            wrm(idx, d[7:0]);
            rd_chk(8'h30 + 8'(idx * 4), m[idx]);
            chk_out();
        end
        trusted_mode_input <= 1'b1;
        repeat (4) @(posedge clk);
        wrm(2, 8'hFF);
        wrm(5, 8'hFF);
        rd_chk(8'h38, m[2]);
        rd_chk(8'h44, m[5]);
        chk_out();
        trusted_mode_input <= 1'b0;
        repeat (4) @(posedge clk);
        wrm(5, 8'hC0);
        chk_out();
        csc_host_inst.wr(8'h54, 8'h01);
        wd_case(8'h04, 4 * B0);
        wd_case(8'h84, 4 * B1);
        wd_case(8'h08, 8 * B0);
        wd_case(8'h00, 0);
        wd_start(8'h1C);
        repeat (20) @(posedge clk);
        csc_host_inst.wr(8'h4C, 8'h00);
        repeat (150) @(posedge clk);
        chk("wdt_stopped", 16'h0, 16'(alarm));
        rd_chk(8'h50, 8'h02);
        repeat (3) @(posedge clk);
        chk("rdata_left", 16'h0, 16'(exp_q.size()));
        finish_test();
    end
endmodule // csc_regs_tb

`default_nettype wire
